// ### hw/dsp_pkg.sv
package dsp_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // apb register map (byte addresses)
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_WAKE   = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;

  // control register fields
  localparam int CTRL_AUX_OFF_LSB = 0;
  localparam int CTRL_GND_OFF_LSB = 3;
  localparam int CTRL_SLEEP_BIT   = 8;
  localparam int AUX_N            = 3;

  // status register fields
  localparam int ST_STATE_LSB  = 0;
  localparam int ST_JOINED_BIT = 4;
  localparam int ST_BATLOW_BIT = 5;
  localparam int ST_HRVLOW_BIT = 6;
  localparam int ST_DUMP_BIT   = 7;
  localparam int ST_HALT_BIT   = 8;
  localparam int ST_REG_BIT    = 9;
  localparam int ST_BOOT_BIT   = 10;

  // reset values
  localparam logic [5:0]  CTRL_RST = 6'h00;
  localparam int          WAKE_W   = 24;
  localparam logic [23:0] WAKE_RST = 24'h0f4240;

  ////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int CLK_MHZ      = 25;
  localparam int WARN_TIME_US = 1000;
  localparam int WARN_CYC     = WARN_TIME_US * CLK_MHZ;
  localparam int WARN_W       = 24;

  ////////////////////////////////////////////////////////////////////////////
  // supply sequencer states, gray along cold -> wait -> on -> warn -> off
  typedef enum logic [2:0] {
    DSP_COLD  = 3'b000,
    DSP_WAIT  = 3'b001,
    DSP_ON    = 3'b011,
    DSP_WARN  = 3'b010,
    DSP_OFF   = 3'b110,
    DSP_SLEEP = 3'b111
  } dsp_state_e;

  // threshold comparator flags, one bit per comparison
  typedef struct packed {
    logic sts_above_cold_start;   // cold_start_end_thr
    logic sts_above_apart;        // floor_high_thr_apart
    logic sts_above_joined;       // floor_high_thr_joined
    logic sts_at_app_low;         // app_ceiling_low_thr reached
    logic store_above_app_high;   // app_ceiling_high_thr
    logic store_above_app_low;    // app_ceiling_low_thr
    logic lts_below_floor_low;    // battery_floor_low_thr
    logic lts_above_floor_high;   // battery_floor_high_thr
    logic store_above_chg_high;   // charge_ceiling_high_thr
    logic store_above_chg_low;    // charge_ceiling_low_thr
    logic harvester_low;
  } dsp_cmp_s;

  // power switch and converter controls
  typedef struct packed {
    logic             main_supply_out;
    logic [AUX_N-1:0] aux_supply_out;
    logic [AUX_N-1:0] aux_ground_switch;
    logic             main_regulated;
    logic             store_link;
    logic             conv_enable;
    logic             conv_mppt;
    logic             conv_to_lts;
    logic             floor_sel_joined;
  } dsp_pwr_s;

endpackage

// ### hw/dsp_sequencer.sv
// Local design decisions: the address map and the APB slave port.
`timescale 1ns/1ps
// Functional notes
// - enter battery protection when long-term store falls below floor low threshold
// - entering protection drives the battery-low indicator high
// - protection opens the switch between long-term and short-term stores
// - in protection outputs stay fed by the boost converter only
// - sleep turns main supply off; configuration access refused meanwhile
// - wake pin or wake timer expiry leaves sleep, main supply back on
// - in normal mode config may disconnect aux outputs and their ground switches
// - active floor high threshold follows store connection state
// - cold start charges short-term store; above cold-start threshold boot, MPPT
// - after boot connect main supply once store above active floor high
// - stores apart: redirect converter to long-term store at app ceiling low
// - stores apart: redirect back to short-term store at active floor high
// - long-term above floor high: join stores, clear battery-low indicator
// - charged battery at start: join first, boot, then main supply on
// - store at app ceiling: main supply switches to regulated form
// - battery above app ceiling at start: main supply regulated from outset
// - halt converter at charge ceiling high threshold
// - restart converter at charge ceiling low threshold, hysteretic
// - energy below minimum: warn on battery-low, then shut application down
// - harvester below minimum switches boost converter off
// - harvester-low indicator reports harvester detection result
// - indicators and digital outputs are active high
module dsp_sequencer #(
  parameter int WARN_CYCLES = dsp_pkg::WARN_CYC
) (
  // clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // apb slave
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [7:0]       paddr,
  input  wire logic [31:0]      pwdata,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  // analog side
  input  wire dsp_pkg::dsp_cmp_s cmp,
  input  wire logic             wake_up_pin,
  output dsp_pkg::dsp_pwr_s     pwr,
  // indicators
  output logic                  battery_low_ind,
  output logic                  harvester_low_ind
);

  ////////////////////////////////////////////////////////////////////////////
  // state
  dsp_pkg::dsp_state_e           state;
  dsp_pkg::dsp_state_e           next_state;
  dsp_pkg::dsp_cmp_s             cmp_q;
  logic                          joined;
  logic                          booted;
  logic                          dump;
  logic                          halt;
  logic                          regulated;
  logic                          bat_low;
  logic                          hrv_low;
  logic [dsp_pkg::AUX_N-1:0]     aux_off;
  logic [dsp_pkg::AUX_N-1:0]     gnd_off;
  logic [dsp_pkg::WAKE_W-1:0]    wake_limit;
  logic [dsp_pkg::WAKE_W-1:0]    wake_cnt;
  logic [dsp_pkg::WARN_W-1:0]    warn_cnt;

  localparam logic [dsp_pkg::WARN_W-1:0] WARN_LAST = dsp_pkg::WARN_W'(WARN_CYCLES - 1);

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ref_addr);
    hit = (a == ref_addr);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // apb decode
  wire logic sleeping  = (state == dsp_pkg::DSP_SLEEP);
  wire logic acc       = psel && penable;
  wire logic hit_ctrl  = hit(paddr, dsp_pkg::ADDR_CTRL);
  wire logic hit_wake  = hit(paddr, dsp_pkg::ADDR_WAKE);
  wire logic hit_stat  = hit(paddr, dsp_pkg::ADDR_STATUS);
  wire logic mapped    = hit_ctrl || hit_wake || hit_stat;
  wire logic refuse    = sleeping || !mapped;
  wire logic wr_ctrl   = acc && pwrite && hit_ctrl && !sleeping;
  wire logic wr_wake   = acc && pwrite && hit_wake && !sleeping;
  wire logic sleep_req = wr_ctrl && pwdata[dsp_pkg::CTRL_SLEEP_BIT];

  wire logic [31:0] ctrl_view = {26'h0000000, gnd_off, aux_off};
  wire logic [31:0] wake_view = {8'h00, wake_limit};
  wire logic [31:0] stat_view = {21'h000000, booted, regulated, halt, dump, hrv_low,
                                 bat_low, joined, 1'b0, state};
  wire logic [31:0] rd_mux    = hit_ctrl ? ctrl_view :
                                hit_wake ? wake_view :
                                hit_stat ? stat_view : 32'h00000000;

  assign pready  = 1'b1;
  assign pslverr = acc && refuse;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= sleeping ? 32'h00000000 : rd_mux;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      aux_off    <= dsp_pkg::CTRL_RST[2:0];
      gnd_off    <= dsp_pkg::CTRL_RST[5:3];
      wake_limit <= dsp_pkg::WAKE_RST;
    end else begin
      if (wr_ctrl) begin
        aux_off <= pwdata[dsp_pkg::CTRL_AUX_OFF_LSB +: dsp_pkg::AUX_N];
        gnd_off <= pwdata[dsp_pkg::CTRL_GND_OFF_LSB +: dsp_pkg::AUX_N];
      end
      if (wr_wake) begin
        wake_limit <= pwdata[dsp_pkg::WAKE_W-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // comparator flags and hysteresis
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp_q <= '0;
    end else begin
      cmp_q <= cmp;
    end
  end

  // flags lag the link switch by two edges; select by the link state they saw
  logic [1:0] link_seen;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link_seen <= 2'b00;
    end else begin
      link_seen <= {link_seen[0], pwr.store_link};
    end
  end

  // active floor high threshold follows connection state
  wire logic above_floor = link_seen[1] ? cmp_q.sts_above_joined : cmp_q.sts_above_apart;
  wire logic cold_done   = cmp_q.sts_above_cold_start;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      joined  <= 1'b0;
      bat_low <= 1'b1;
    end else if (cmp_q.lts_below_floor_low) begin
      joined  <= 1'b0;
      bat_low <= 1'b1;
    end else if (cmp_q.lts_above_floor_high) begin
      joined  <= 1'b1;
      bat_low <= 1'b0;
    end else if (state == dsp_pkg::DSP_WARN) begin
      bat_low <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dump <= 1'b0;
    end else if (joined) begin
      dump <= 1'b0;
    end else if (!above_floor) begin
      dump <= 1'b0;
    end else if (cmp_q.sts_at_app_low && booted) begin
      dump <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      halt <= 1'b0;
    end else if (cmp_q.store_above_chg_high) begin
      halt <= 1'b1;
    end else if (!cmp_q.store_above_chg_low) begin
      halt <= 1'b0;
    end
  end

  // regulation tracked even while main is off so it holds from the outset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      regulated <= 1'b0;
    end else if (cmp_q.store_above_app_high) begin
      regulated <= 1'b1;
    end else if (!cmp_q.store_above_app_low) begin
      regulated <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      booted  <= 1'b0;
      hrv_low <= 1'b0;
    end else begin
      hrv_low <= cmp_q.harvester_low;
      if (cold_done) begin
        booted <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // supply sequencer
  wire logic wake_hit  = (wake_cnt >= wake_limit);
  wire logic warn_done = (warn_cnt == WARN_LAST);

  always_comb begin
    next_state = state;
    case (state)
      dsp_pkg::DSP_COLD:  if (cold_done) next_state = dsp_pkg::DSP_WAIT;
      dsp_pkg::DSP_WAIT:  if (above_floor) next_state = dsp_pkg::DSP_ON;
      dsp_pkg::DSP_ON: begin
        if (sleep_req) begin
          next_state = dsp_pkg::DSP_SLEEP;
        end else if (!above_floor) begin
          next_state = dsp_pkg::DSP_WARN;
        end
      end
      dsp_pkg::DSP_WARN: begin
        if (above_floor) begin
          next_state = dsp_pkg::DSP_ON;
        end else if (warn_done) begin
          next_state = dsp_pkg::DSP_OFF;
        end
      end
      dsp_pkg::DSP_OFF:   if (above_floor) next_state = dsp_pkg::DSP_ON;
      dsp_pkg::DSP_SLEEP: if (wake_up_pin || wake_hit) next_state = dsp_pkg::DSP_ON;
      default:            next_state = dsp_pkg::DSP_COLD;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= dsp_pkg::DSP_COLD;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_cnt <= '0;
      warn_cnt <= '0;
    end else begin
      wake_cnt <= sleeping ? wake_cnt + 1'b1 : '0;
      warn_cnt <= (state == dsp_pkg::DSP_WARN) ? warn_cnt + 1'b1 : '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  wire logic main_next = (next_state == dsp_pkg::DSP_ON) || (next_state == dsp_pkg::DSP_WARN);
  wire logic [dsp_pkg::AUX_N-1:0] aux_mask = joined ? ~aux_off : '1;
  wire logic [dsp_pkg::AUX_N-1:0] gnd_mask = joined ? ~gnd_off : '1;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwr <= '0;
    end else begin
      pwr.main_supply_out   <= main_next;
      pwr.aux_supply_out    <= {dsp_pkg::AUX_N{main_next}} & aux_mask;
      pwr.aux_ground_switch <= {dsp_pkg::AUX_N{main_next}} & gnd_mask;
      pwr.main_regulated    <= regulated;
      pwr.store_link        <= joined;
      pwr.conv_enable       <= !cmp_q.harvester_low && !halt;
      pwr.conv_mppt         <= booted;
      pwr.conv_to_lts       <= dump;
      pwr.floor_sel_joined  <= joined;
    end
  end

  assign battery_low_ind   = bat_low;
  assign harvester_low_ind = hrv_low;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_protect_cause;
    cmp_q.lts_below_floor_low;
  endsequence

  sequence s_protect_effect;
    !joined && bat_low ##1 !pwr.store_link;
  endsequence

  property p_protect;
    @(posedge pclk) disable iff (!presetn) s_protect_cause |=> s_protect_effect;
  endproperty

  a_protect_entry: assert property (p_protect)
    else $error("protection not entered");

  a_battery_low_set: assert property (@(posedge pclk) disable iff (!presetn)
    cmp_q.lts_below_floor_low |=> battery_low_ind)
    else $error("battery low not raised");

  a_join_clears: assert property (@(posedge pclk) disable iff (!presetn)
    !cmp_q.lts_below_floor_low && cmp_q.lts_above_floor_high |=> joined && !battery_low_ind)
    else $error("join did not clear battery low");

  a_sleep_off: assert property (@(posedge pclk) disable iff (!presetn)
    state == dsp_pkg::DSP_SLEEP |=> !pwr.main_supply_out || next_state != dsp_pkg::DSP_SLEEP)
    else $error("main on while sleeping");

  a_sleep_refuse: assert property (@(posedge pclk) disable iff (!presetn)
    sleeping && psel && penable |-> pslverr && !wr_ctrl && !wr_wake)
    else $error("access not refused in sleep");

  a_wake_pin: assert property (@(posedge pclk) disable iff (!presetn)
    sleeping && wake_up_pin |=> state == dsp_pkg::DSP_ON && pwr.main_supply_out)
    else $error("wake pin ignored");

  a_floor_select: assert property (@(posedge pclk) disable iff (!presetn)
    above_floor == ($past(pwr.store_link, 2) ? cmp_q.sts_above_joined : cmp_q.sts_above_apart)
    && pwr.floor_sel_joined == $past(joined))
    else $error("floor selection wrong");

  a_cold_boot: assert property (@(posedge pclk) disable iff (!presetn)
    state == dsp_pkg::DSP_COLD && cold_done |=> booted && state == dsp_pkg::DSP_WAIT
    ##1 pwr.conv_mppt)
    else $error("cold start did not boot");

  a_main_connect: assert property (@(posedge pclk) disable iff (!presetn)
    state == dsp_pkg::DSP_WAIT && above_floor |=> pwr.main_supply_out)
    else $error("main not connected");

  a_no_early_main: assert property (@(posedge pclk) disable iff (!presetn)
    !booted |-> !pwr.main_supply_out)
    else $error("main on before boot");

  a_dump_set: assert property (@(posedge pclk) disable iff (!presetn)
    !joined && booted && above_floor && cmp_q.sts_at_app_low |=> dump ##1 pwr.conv_to_lts)
    else $error("no redirect to long-term store");

  a_dump_clear: assert property (@(posedge pclk) disable iff (!presetn)
    !above_floor |=> !dump)
    else $error("redirect not withdrawn");

  a_regulate: assert property (@(posedge pclk) disable iff (!presetn)
    cmp_q.store_above_app_high |=> regulated ##1 pwr.main_regulated)
    else $error("main not regulated");

  a_halt_charge: assert property (@(posedge pclk) disable iff (!presetn)
    cmp_q.store_above_chg_high |=> halt ##1 !pwr.conv_enable)
    else $error("converter not halted");

  a_restart_charge: assert property (@(posedge pclk) disable iff (!presetn)
    halt && !cmp_q.store_above_chg_high && !cmp_q.store_above_chg_low |=> !halt)
    else $error("converter not restarted");

  a_warn_first: assert property (@(posedge pclk) disable iff (!presetn)
    state == dsp_pkg::DSP_WARN |=> battery_low_ind || state != dsp_pkg::DSP_WARN)
    else $error("no warning before shutdown");

  a_shutdown: assert property (@(posedge pclk) disable iff (!presetn)
    state == dsp_pkg::DSP_WARN && warn_done && !above_floor |=> !pwr.main_supply_out)
    else $error("shutdown not performed");

  a_harvester_off: assert property (@(posedge pclk) disable iff (!presetn)
    cmp_q.harvester_low |=> !pwr.conv_enable && harvester_low_ind)
    else $error("converter on with harvester low");

  a_aux_mask: assert property (@(posedge pclk) disable iff (!presetn)
    joined && main_next |=> pwr.aux_supply_out == ~$past(aux_off))
    else $error("aux disconnect ignored");

  a_aux_protect: assert property (@(posedge pclk) disable iff (!presetn)
    !joined && main_next |=> pwr.aux_supply_out == '1 && !pwr.store_link)
    else $error("aux not sustained by converter");

endmodule

// ### test/dsp_analog_model.sv
`timescale 1ns/1ps
module dsp_analog_model #(
  parameter int COLD_MV   = 1300,
  parameter int APART_MV  = 2000,
  parameter int JOINED_MV = 2400,
  parameter int FL_LO_MV  = 2200,
  parameter int FL_HI_MV  = 2600,
  parameter int APP_LO_MV = 3300,
  parameter int APP_HI_MV = 3500,
  parameter int CHG_LO_MV = 3900,
  parameter int CHG_HI_MV = 4100
) (
  // clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // store levels in millivolts
  input  var  int                sts_mv,
  input  var  int                lts_mv,
  input  wire logic              hrv_low,
  // device side
  input  wire dsp_pkg::dsp_pwr_s pwr,
  output dsp_pkg::dsp_cmp_s      cmp
);
  int store_mv;

  // a closed store link makes both stores one node
  assign store_mv = pwr.store_link ? lts_mv : sts_mv;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp <= '0;
    end else begin
      cmp.sts_above_cold_start <= store_mv > COLD_MV;
      cmp.sts_above_apart      <= store_mv > APART_MV;
      cmp.sts_above_joined     <= store_mv > JOINED_MV;
      cmp.sts_at_app_low       <= store_mv >= APP_LO_MV;
      cmp.store_above_app_high <= store_mv > APP_HI_MV;
      cmp.store_above_app_low  <= store_mv > APP_LO_MV;
      cmp.lts_below_floor_low  <= lts_mv < FL_LO_MV;
      cmp.lts_above_floor_high <= lts_mv > FL_HI_MV;
      cmp.store_above_chg_high <= store_mv > CHG_HI_MV;
      cmp.store_above_chg_low  <= store_mv > CHG_LO_MV;
      cmp.harvester_low        <= hrv_low;
    end
  end
endmodule

// ### test/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic              pclk    = 1'b0;
  logic              presetn = 1'b0;
  logic              psel    = 1'b0;
  logic              penable = 1'b0;
  logic              pwrite  = 1'b0;
  logic [7:0]        paddr   = 8'h00;
  logic [31:0]       pwdata  = 32'h0;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic              wake_up_pin = 1'b0;
  logic              hrv_low     = 1'b0;
  logic              battery_low_ind;
  logic              harvester_low_ind;
  int                sts_mv = 0;
  int                lts_mv = 0;
  dsp_pkg::dsp_cmp_s cmp;
  dsp_pkg::dsp_pwr_s pwr;
  logic [31:0]       rd;
  logic              er;
  int                fail_count = 0;
  int                checks     = 0;

  always #20 pclk = ~pclk;

  dsp_sequencer #(.WARN_CYCLES(8)) uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cmp(cmp), .wake_up_pin(wake_up_pin), .pwr(pwr),
    .battery_low_ind(battery_low_ind), .harvester_low_ind(harvester_low_ind)
  );

  dsp_analog_model model (
    .pclk(pclk), .presetn(presetn), .sts_mv(sts_mv), .lts_mv(lts_mv),
    .hrv_low(hrv_low), .pwr(pwr), .cmp(cmp)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    paddr   <= a;
    pwrite  <= w;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // set store levels, then let comparator and sequencer pipeline settle
  task automatic setv(input int s, input int l);
    @(posedge pclk);
    sts_mv <= s;
    lts_mv <= l;
    repeat (6) @(posedge pclk);
  endtask

  task automatic done(input string n);
    $display("test %s finished", n);
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge pclk);
    fail_count++;
    results();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    chk("reset pwr", 32'(pwr), 32'h0);
    chk("reset batlow", 32'(battery_low_ind), 32'h1);
    apb(dsp_pkg::ADDR_WAKE, 1'b0, 32'h0);
    chk("wake reset", rd, 32'h000f4240);
    apb(dsp_pkg::ADDR_STATUS, 1'b0, 32'h0);
    chk("status reset", rd & 32'h27, 32'h20);
    apb(8'h0c, 1'b0, 32'h0);
    chk("unmapped err", 32'(er), 32'h1);
    done("reset");
    setv(1500, 0);
    chk("mppt", 32'(pwr.conv_mppt), 32'h1);
    chk("main before floor", 32'(pwr.main_supply_out), 32'h0);
    setv(2100, 0);
    chk("main on", 32'(pwr.main_supply_out), 32'h1);
    chk("link open", 32'(pwr.store_link), 32'h0);
    apb(dsp_pkg::ADDR_STATUS, 1'b0, 32'h0);
    chk("state on", rd & 32'h407, 32'h403);
    done("cold start");
    setv(3400, 0);
    chk("dump on", 32'(pwr.conv_to_lts), 32'h1);
    setv(2900, 0);
    chk("dump held", 32'(pwr.conv_to_lts), 32'h1);
    setv(2000, 0);
    chk("dump off", 32'(pwr.conv_to_lts), 32'h0);
    chk("warn main", 32'(pwr.main_supply_out), 32'h1);
    repeat (10) @(posedge pclk);
    chk("shut main", 32'(pwr.main_supply_out), 32'h0);
    setv(2100, 0);
    chk("restart main", 32'(pwr.main_supply_out), 32'h1);
    done("store dump");
    setv(2100, 2700);
    chk("joined", 32'(pwr.store_link), 32'h1);
    chk("batlow clear", 32'(battery_low_ind), 32'h0);
    chk("floor sel", 32'(pwr.floor_sel_joined), 32'h1);
    chk("aux all", {29'h0, pwr.aux_supply_out}, 32'h7);
    apb(dsp_pkg::ADDR_CTRL, 1'b1, 32'h00000015);
    repeat (3) @(posedge pclk);
    chk("aux off", {29'h0, pwr.aux_supply_out}, 32'h2);
    chk("gnd off", {29'h0, pwr.aux_ground_switch}, 32'h5);
    apb(dsp_pkg::ADDR_CTRL, 1'b0, 32'h0);
    chk("ctrl read", rd, 32'h15);
    apb(dsp_pkg::ADDR_CTRL, 1'b1, 32'h0);
    done("join and aux");
    setv(2100, 3600);
    chk("regulated", 32'(pwr.main_regulated), 32'h1);
    setv(2100, 4200);
    chk("halt", 32'(pwr.conv_enable), 32'h0);
    setv(2100, 4000);
    chk("halt held", 32'(pwr.conv_enable), 32'h0);
    setv(2100, 3800);
    chk("restart conv", 32'(pwr.conv_enable), 32'h1);
    @(posedge pclk);
    hrv_low <= 1'b1;
    repeat (5) @(posedge pclk);
    chk("hrv conv off", 32'(pwr.conv_enable), 32'h0);
    chk("hrv ind", 32'(harvester_low_ind), 32'h1);
    hrv_low <= 1'b0;
    repeat (5) @(posedge pclk);
    chk("hrv ind clear", 32'(harvester_low_ind), 32'h0);
    done("charge limits");
    apb(dsp_pkg::ADDR_CTRL, 1'b1, 32'h100);
    @(posedge pclk);
    chk("sleep main", 32'(pwr.main_supply_out), 32'h0);
    apb(dsp_pkg::ADDR_STATUS, 1'b0, 32'h0);
    chk("sleep refuse", {31'h0, er}, 32'h1);
    chk("sleep data", rd, 32'h0);
    wake_up_pin <= 1'b1;
    repeat (2) @(posedge pclk);
    wake_up_pin <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("pin wake", 32'(pwr.main_supply_out), 32'h1);
    apb(dsp_pkg::ADDR_WAKE, 1'b1, 32'h14);
    apb(dsp_pkg::ADDR_CTRL, 1'b1, 32'h100);
    repeat (8) @(posedge pclk);
    chk("timer sleeping", 32'(pwr.main_supply_out), 32'h0);
    repeat (22) @(posedge pclk);
    chk("timer wake", 32'(pwr.main_supply_out), 32'h1);
    done("sleep");
    setv(2100, 2300);
    chk("warn batlow", 32'(battery_low_ind), 32'h1);
    chk("warn main on", 32'(pwr.main_supply_out), 32'h1);
    repeat (12) @(posedge pclk);
    chk("off main", 32'(pwr.main_supply_out), 32'h0);
    setv(2100, 2700);
    chk("back on", 32'(pwr.main_supply_out), 32'h1);
    setv(2100, 2100);
    chk("prot batlow", 32'(battery_low_ind), 32'h1);
    chk("prot link", 32'(pwr.store_link), 32'h0);
    chk("prot main", 32'(pwr.main_supply_out), 32'h1);
    done("protection");
    @(posedge pclk);
    presetn <= 1'b0;
    sts_mv  <= 3600;
    lts_mv  <= 3600;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    repeat (14) @(posedge pclk);
    chk("charged link", 32'(pwr.store_link), 32'h1);
    chk("charged main", 32'(pwr.main_supply_out), 32'h1);
    chk("charged reg", 32'(pwr.main_regulated), 32'h1);
    done("charged start");
    results();
  end
endmodule
